// ### scs_sync.sv
/*
 * Holds the shared package of the scanner channel handshake block (pin
 * widths, reset levels, timing constants, measurement states) and a
 * two-flip-flop synchroniser for a group of pin inputs.
 * Assumes one clock, a synchronous active-high reset and a clock enable
 * that freezes every flip-flop while low.
 */
`timescale 1ns/100ps

package scs_pkg;
   localparam int            CH_W          = 8;      // channel number width
   localparam int            RES_W         = 32;     // result word width
   localparam int            CLK_PERIOD_NS = 10;     // 100 MHz clock
   localparam int            T_RESP_NS     = 60000;  // typical response, ns
   localparam int            RESP_CYC      = T_RESP_NS / CLK_PERIOD_NS;
   localparam int            RESP_W        = 16;     // response counter width
   localparam logic [CH_W-1:0] CH_SYNC_RST = 8'hFF;  // lines idle high
   localparam logic          STB_SYNC_RST  = 1'b1;   // strobe idle high
   localparam logic          TRG_SYNC_RST  = 1'b0;   // trigger idle low
   localparam logic [CH_W-1:0] CH_RST      = 8'h00;  // channel after reset
   localparam logic [RES_W-1:0] RES_RST    = 32'h0000_0000;
   localparam logic          STAT_N_RST    = 1'b0;   // status asserted (low)

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ANALOG,
      ST_FINISH
   } scs_state_e;
endpackage : scs_pkg

module scs_sync #(
   parameter int          W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_clk_en,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // one two-stage chain per bit; the first stage feeds the second only
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_comb begin
         meta_d[b] = i_clk_en ? i_async[b] : meta_q[b];
         sync_d[b] = i_clk_en ? meta_q[b]  : sync_q[b];
      end
   end

   // register both stages
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         meta_q <= RST;
         sync_q <= RST;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q;
endmodule : scs_sync

// ### scs_handshake.sv
/*
 * Scanner-side handshake port of a capacitance meter: takes the channel
 * number, channel strobe and outside trigger from the scanner pins,
 * starts measurements, and drives the active-low analog-done and
 * measurement-done status lines.
 * Assumes the pins are asynchronous, the measurement engine reports the
 * end of its analog phase and of the whole measurement as one-cycle
 * pulses on this clock, and the mode inputs come from local logic.
 */
`timescale 1ns/100ps

module scs_handshake
   import scs_pkg::*;
#(
   parameter int P_RESP_CYC = scs_pkg::RESP_CYC
) (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_sys_rst,
   input  wire logic                      i_clk_en,
   input  wire logic [scs_pkg::CH_W-1:0]  i_channel_number_n,
   input  wire logic                      i_channel_strobe_n,
   input  wire logic                      i_outside_trigger_in,
   input  wire logic                      i_outside_trigger_in_mode,
   input  wire logic                      i_multi_chan_en,
   input  wire logic                      i_analog_end,
   input  wire logic                      i_meas_end,
   input  wire logic [scs_pkg::RES_W-1:0] i_result,
   output logic                           o_analog_done_n,
   output logic                           o_measurement_done_n,
   output logic [scs_pkg::CH_W-1:0]       o_channel,
   output logic                           o_meas_start,
   output logic [scs_pkg::RES_W-1:0]      o_result,
   output logic                           o_resp_late
);
   import scs_pkg::*;

   logic [CH_W-1:0]  ch_n_s;
   logic             stb_n_s;
   logic             trg_s;
   logic             stb_n_prev_q, stb_n_prev_d;
   logic             trg_prev_q,   trg_prev_d;
   logic             stb_fall, trg_rise, accept, load;
   scs_state_e       state_q, state_d;
   logic [CH_W-1:0]  chan_q, chan_d;
   logic [RES_W-1:0] res_q, res_d;
   logic             idx_n_q, idx_n_d;
   logic             eom_n_q, eom_n_d;
   logic             start_q, start_d;
   logic [RESP_W-1:0] resp_q, resp_d;
   logic             late_q, late_d;

   // pin inputs pass two flip-flops first
   scs_sync #(.W(CH_W), .RST(CH_SYNC_RST)) u_ch_sync (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_clk_en  (i_clk_en),
      .i_async   (i_channel_number_n),
      .o_sync    (ch_n_s)
   );
   scs_sync #(.W(2), .RST({STB_SYNC_RST, TRG_SYNC_RST})) u_ctl_sync (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_clk_en  (i_clk_en),
      .i_async   ({i_channel_strobe_n, i_outside_trigger_in}),
      .o_sync    ({stb_n_s, trg_s})
   );

   // trigger sources and acceptance
   always_comb begin
      stb_n_prev_d = i_clk_en ? stb_n_s : stb_n_prev_q;
      trg_prev_d   = i_clk_en ? trg_s   : trg_prev_q;
      stb_fall = stb_n_prev_q & ~stb_n_s & i_multi_chan_en;
      trg_rise = ~trg_prev_q & trg_s & i_outside_trigger_in_mode;
      accept   = i_clk_en & (state_q == ST_IDLE) & (stb_fall | trg_rise);
      load     = accept & i_multi_chan_en & ~stb_n_s;
   end

   // measurement sequence, status lines, channel and result
   always_comb begin
      state_d = state_q;
      chan_d  = chan_q;
      res_d   = res_q;
      idx_n_d = idx_n_q;
      eom_n_d = eom_n_q;
      start_d = start_q;                                    // frozen when low
      resp_d  = resp_q;
      late_d  = late_q;
      if (i_clk_en) begin
         start_d = 1'b0;                                    // one-cycle pulse
         case (state_q)
            ST_IDLE: begin
               if (accept) begin
                  state_d = ST_ANALOG;
                  start_d = 1'b1;
                  idx_n_d = 1'b1;
                  eom_n_d = 1'b1;
                  resp_d  = '0;
                  late_d  = 1'b0;
               end
               if (load) begin
                  chan_d = ~ch_n_s;
               end
            end
            ST_ANALOG: begin
               if (i_analog_end) begin
                  state_d = ST_FINISH;
                  idx_n_d = 1'b0;
               end
            end
            ST_FINISH: begin
               if (i_meas_end) begin
                  state_d = ST_IDLE;
                  res_d   = i_result;
                  eom_n_d = 1'b0;
               end
            end
            default: state_d = ST_IDLE;
         endcase
         // watch the time from trigger to analog-done
         if (state_q == ST_ANALOG) begin
            if (resp_q < RESP_W'(P_RESP_CYC)) begin
               resp_d = resp_q + RESP_W'(1);
            end else begin
               late_d = 1'b1;
            end
         end
         if (!i_multi_chan_en) begin
            idx_n_d = 1'b0;
            eom_n_d = 1'b0;
         end
      end
   end

   // register the handshake state
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         stb_n_prev_q <= STB_SYNC_RST;
         trg_prev_q   <= TRG_SYNC_RST;
         state_q      <= ST_IDLE;
         chan_q       <= CH_RST;
         res_q        <= RES_RST;
         idx_n_q      <= STAT_N_RST;
         eom_n_q      <= STAT_N_RST;
         start_q      <= 1'b0;
         resp_q       <= '0;
         late_q       <= 1'b0;
      end else begin
         stb_n_prev_q <= stb_n_prev_d;
         trg_prev_q   <= trg_prev_d;
         state_q      <= state_d;
         chan_q       <= chan_d;
         res_q        <= res_d;
         idx_n_q      <= idx_n_d;
         eom_n_q      <= eom_n_d;
         start_q      <= start_d;
         resp_q       <= resp_d;
         late_q       <= late_d;
      end
   end

   // outputs straight from flip-flops
   assign o_analog_done_n      = idx_n_q;
   assign o_measurement_done_n = eom_n_q;
   assign o_channel            = chan_q;
   assign o_meas_start         = start_q;
   assign o_result             = res_q;
   assign o_resp_late          = late_q;

   // checks on the handshake
   a_strobe_loads_chan: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      (i_clk_en && state_q == ST_IDLE && stb_fall && !stb_n_s)
      |=> (state_q == ST_ANALOG && chan_q == ~$past(ch_n_s)))
      else $error("strobe did not load channel and start");

   a_start_has_cause: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      o_meas_start |-> $past(i_outside_trigger_in_mode && trg_rise
                             || i_multi_chan_en && stb_fall))
      else $error("start without an allowed trigger");

   a_start_clears_stat: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      (o_meas_start && $past(i_multi_chan_en))
      |-> (o_analog_done_n && o_measurement_done_n))
      else $error("status not cleared at start");

   a_index_on_end: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      (i_clk_en && state_q == ST_ANALOG && i_analog_end && i_multi_chan_en)
      |=> (!o_analog_done_n && o_measurement_done_n))
      else $error("analog-done not asserted at analog end");

   a_eom_on_end: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      (i_clk_en && state_q == ST_FINISH && i_meas_end)
      |=> (!o_measurement_done_n && state_q == ST_IDLE
           && o_result == $past(i_result)))
      else $error("measurement-done or result wrong at end");

   a_result_stable: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      (!o_measurement_done_n && $past(!o_measurement_done_n)
       && i_multi_chan_en) |-> $stable(o_result))
      else $error("result changed while measurement-done asserted");

   a_off_holds_low: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      ($past(i_clk_en && !i_multi_chan_en))
      |-> (!o_analog_done_n && !o_measurement_done_n))
      else $error("status not low with correction off");

   a_chan_only_trig: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      $changed(o_channel) |-> $past(load))
      else $error("channel changed without a trigger");

   a_late_flag: assert property (@(posedge i_ref_clk)
      disable iff (i_sys_rst)
      (o_meas_start && i_multi_chan_en) |-> !o_resp_late)
      else $error("late flag not cleared at start");
endmodule : scs_handshake

// ### scs_scanner_model.sv
/*
 * Behavioural scanner/handler that drives the channel lines, channel
 * strobe and outside trigger pins of the scanner channel handshake port.
 * Assumes the caller enters each task just after a clock edge and that
 * the lines idle high, as the pull-ups of the optocoupler inputs do.
 */
`timescale 1ns/100ps

module scs_scanner_model (
   output logic [7:0] o_channel_number_n,
   output logic       o_channel_strobe_n,
   output logic       o_outside_trigger_in
);
   // released pins: lines and strobe pulled high, trigger tied low
   initial begin
      o_channel_number_n   = 8'hFF;
      o_channel_strobe_n   = 1'b1;
      o_outside_trigger_in = 1'b0;
   end

   // strobe high, present the number, then strobe low to load it
   task automatic select_channel(input logic [7:0] ch);
      o_channel_strobe_n = 1'b1;
      #20;
      o_channel_number_n = ~ch;
      #20;
      o_channel_strobe_n = 1'b0;
   endtask : select_channel

   // release the strobe and let the lines float back high
   task automatic release_lines();
      o_channel_strobe_n = 1'b1;
      o_channel_number_n = 8'hFF;
   endtask : release_lines

   // one trigger pulse of the 1 us minimum width, rising edge first
   task automatic pulse_trigger();
      o_outside_trigger_in = 1'b1;
      fork
         #1000 o_outside_trigger_in = 1'b0;
      join_none
   endtask : pulse_trigger
endmodule : scs_scanner_model

// ### test_scanner_channel_handshake.sv
/*
 * Self-checking testbench of the scanner channel handshake port.
 * Assumes the scanner model drives the pins and the bench plays the
 * measurement engine; the response limit is shortened to 20 cycles.
 */
`timescale 1ns/100ps

module test_scanner_channel_handshake;
   import scs_pkg::*;
   localparam int RESP = 20;
   logic             i_ref_clk = 1'b0;
   logic             i_sys_rst = 1'b1;
   logic             ext_mode  = 1'b0;
   logic             multi     = 1'b1;
   logic             aend      = 1'b0;
   logic             mend      = 1'b0;
   logic             clk_en    = 1'b1;
   logic [RES_W-1:0] res_in    = '0;
   logic [CH_W-1:0]  lines_n;
   logic             stb_n, trig, adone_n, mdone_n, start, late;
   logic [CH_W-1:0]  chan;
   logic [RES_W-1:0] res_out;
   int               fail_count = 0;
   int               checks = 0;
   int               cyc = 0;

   scs_scanner_model model (
      .o_channel_number_n   (lines_n),
      .o_channel_strobe_n   (stb_n),
      .o_outside_trigger_in (trig)
   );

   scs_handshake #(.P_RESP_CYC(RESP)) DUT (
      .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
      .i_channel_number_n(lines_n), .i_channel_strobe_n(stb_n),
      .i_outside_trigger_in(trig), .i_outside_trigger_in_mode(ext_mode),
      .i_multi_chan_en(multi), .i_analog_end(aend), .i_meas_end(mend),
      .i_result(res_in), .o_analog_done_n(adone_n),
      .o_measurement_done_n(mdone_n), .o_channel(chan),
      .o_meas_start(start), .o_result(res_out), .o_resp_late(late)
   );

   // 100 MHz clock
   always #5 i_ref_clk = ~i_ref_clk;

   // hang guard
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // look for the start pulse over the next 10 cycles
   task automatic wait_start(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (10) begin
         @(posedge i_ref_clk);
         #1;
         if (start === 1'b1) seen = 1'b1;
      end
      chk("o_meas_start", exp, seen);
   endtask : wait_start

   // play the engine: analog end after adelay cycles, then the end
   task automatic finish_meas(input logic hi, input int adelay,
                              input logic [31:0] r);
      chk("o_analog_done_n", hi, adone_n);
      chk("o_measurement_done_n", hi, mdone_n);
      repeat (adelay) @(posedge i_ref_clk);
      #1;
      aend = 1'b1;
      @(posedge i_ref_clk);
      #1;
      aend = 1'b0;
      chk("o_analog_done_n", 1'b0, adone_n);
      chk("o_measurement_done_n", hi, mdone_n);
      chk("o_resp_late", adelay > RESP, late);
      model.release_lines();
      res_in = r;
      mend   = 1'b1;
      @(posedge i_ref_clk);
      #1;
      mend = 1'b0;
      chk("o_measurement_done_n", 1'b0, mdone_n);
      chk("o_result", r, res_out);
   endtask : finish_meas

   task automatic t_reset();
      chk("o_analog_done_n", 1'b0, adone_n);
      chk("o_measurement_done_n", 1'b0, mdone_n);
      chk("o_channel", 8'h00, chan);
      chk("o_result", 32'h0000_0000, res_out);
      $display("test reset done");
   endtask : t_reset

   // strobe loads channels; later line changes must not take effect
   task automatic t_strobe();
      logic [7:0] chs [2];
      chs = '{8'h80, 8'h03};
      foreach (chs[k]) begin
         model.select_channel(chs[k]);
         wait_start(1'b1);
         chk("o_channel", chs[k], chan);
         finish_meas(1'b1, 3 + 37 * k, {24'hA5A5A5, chs[k]});
         chk("o_channel", chs[k], chan);
      end
      $display("test strobe done");
   endtask : t_strobe

   // outside trigger refused outside ext mode, honoured inside it
   task automatic t_ext_trigger();
      model.pulse_trigger();
      wait_start(1'b0);
      #1200;
      ext_mode = 1'b1;
      model.pulse_trigger();
      wait_start(1'b1);
      finish_meas(1'b1, 4, 32'h1234_5678);
      chk("o_channel", 8'h03, chan);
      #1200;
      $display("test ext trigger done");
   endtask : t_ext_trigger

   // clock enable low freezes the port; the strobe acts once it returns
   task automatic t_freeze();
      clk_en = 1'b0;
      model.select_channel(8'h11);
      wait_start(1'b0);
      chk("o_channel", 8'h03, chan);
      clk_en = 1'b1;
      wait_start(1'b1);
      chk("o_channel", 8'h11, chan);
      finish_meas(1'b1, 4, 32'hCAFE_0011);
      $display("test freeze done");
   endtask : t_freeze

   // correction off: strobe ignored, status held low
   task automatic t_multi_off();
      multi = 1'b0;
      model.select_channel(8'h05);
      wait_start(1'b0);
      chk("o_analog_done_n", 1'b0, adone_n);
      model.pulse_trigger();
      wait_start(1'b1);
      finish_meas(1'b0, 4, 32'h0F0F_0F0F);
      chk("o_channel", 8'h11, chan);
      $display("test multi off done");
   endtask : t_multi_off

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // main sequence
   initial begin
      repeat (3) @(posedge i_ref_clk);
      #1;
      i_sys_rst = 1'b0;
      t_reset();
      t_strobe();
      t_ext_trigger();
      t_freeze();
      t_multi_off();
      give_verdict();
   end
endmodule : test_scanner_channel_handshake
